// ==== design/logical_io_signal_bank.v ====
// Behaviour
// - Thirty-two independent command driven manual inputs
// - Reset clears every manual input to zero
// - Hold or pulse mode chosen per input
// - Hold: set stays until clear command
// - Pulse: set returns to zero after 5 ms
// - Rising change gives ON, falling gives OFF
// - Direction enables decide which events are stored
// - Each stored event carries the time stamp of its batch's first change
// - Thirty-two logic outputs observed for events, status
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`include "logical_io_regs.vh"

module logical_io_signal_bank #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [31:0] panel_set,
  input wire [31:0] panel_clr,
  input wire [31:0] logic_binary_output,
  output wire [31:0] manual_binary_input
);

  // ============================================================
  // Declarations
  // ============================================================
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1; // Last tick count

  reg [15:0] tick_cnt_r; // Cycle counter inside one tick
  reg tick_r; // One-cycle tick pulse
  reg [31:0] ms_count_r; // Time stamp in ticks
  reg [1:0] ctrl_r; // Direction enables
  reg [31:0] mode_r; // One bit per input: pulse mode
  reg ack_r; // APB access wait state done
  reg [31:0] prdata_r; // Registered read data
  reg [31:0] rd_mux; // Read data select
  reg mapped; // Address hits a register
  reg [31:0] in_prev_r; // Previous manual input status
  reg [31:0] out_prev_r; // Previous logic output status
  reg [127:0] pend_r; // Events waiting for a batch
  reg [31:0] pend_ts_r; // Stamp of the first pending change
  reg [127:0] batch_r; // Events being written out
  reg [31:0] batch_ts_r; // Stamp of the current batch
  reg [6:0] sel_idx; // Lowest pending batch event
  reg sel_any; // Batch has an event
  reg [4:0] wr_ptr_r; // Buffer write pointer
  reg [4:0] rd_ptr_r; // Buffer read pointer
  reg avail_r; // Buffer head read data valid
  reg ovf_r; // Event lost on a full buffer
  integer i; // Encoder loop index
  genvar g; // Cell index

  wire [31:0] status; // Manual input status vector
  wire xfer_done; // APB transfer completes this edge
  wire wr_done; // APB write completes
  wire rd_done; // APB read completes
  wire [31:0] apb_set; // Set commands from software
  wire [31:0] apb_clr; // Clear commands from software
  wire [31:0] cmd_set; // All set commands
  wire [31:0] cmd_clr; // All clear commands
  wire [31:0] in_rise; // Manual input rising
  wire [31:0] in_fall; // Manual input falling
  wire [31:0] out_rise; // Logic output rising
  wire [31:0] out_fall; // Logic output falling
  wire [127:0] cap; // Enabled events seen this cycle
  wire [4:0] evt_count; // Words in the buffer
  wire evt_full; // Buffer full
  wire evt_wr; // Write one event this cycle
  wire evt_pop; // Drop the buffer head
  wire [`EVT_WIDTH-1:0] head; // Buffer head word
  wire [`EVT_WIDTH-1:0] evt_word; // Word being written

  // ============================================================
  // Millisecond tick and time stamp
  // ============================================================
  // Fixed-rate tick from the device clock
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
      ms_count_r <= 32'h00000000;
    end
    else if ({16'h0000, tick_cnt_r} == TICK_LAST)
    begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b1;
      ms_count_r <= ms_count_r + 32'h00000001;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // ============================================================
  // APB slave
  // ============================================================
  // One wait state: read data is loaded, then pready rises
  assign xfer_done = psel & penable & ack_r;
  assign wr_done = xfer_done & pwrite;
  assign rd_done = xfer_done & ~pwrite;
  assign pready = psel & penable & ack_r;
  assign pslverr = xfer_done & ~mapped;
  assign prdata = prdata_r;

  // Address decode and read data select
  always @*
  begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      `CTRL_OFS: rd_mux = {30'h0, ctrl_r};
      `MODE_OFS: rd_mux = mode_r;
      `SET_OFS: rd_mux = 32'h00000000;
      `CLR_OFS: rd_mux = 32'h00000000;
      `IN_STAT_OFS: rd_mux = status;
      `OUT_STAT_OFS: rd_mux = out_prev_r;
      `TIME_OFS: rd_mux = ms_count_r;
      `EVT_STAT_OFS: rd_mux = {23'h0, ovf_r, 3'h0, evt_count};
      // Head info with valid flag; reading the time pops it
      `EVT_INFO_OFS: rd_mux = {avail_r, 23'h0, head[39:32]};
      `EVT_TIME_OFS: rd_mux = avail_r ? head[31:0] : 32'h00000000;
      default:
      begin
        mapped = 1'b0;
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Wait state and read data register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else if (psel && penable && !ack_r)
    begin
      ack_r <= 1'b1;
      prdata_r <= pwrite ? 32'h00000000 : rd_mux;
    end
    else
    begin
      ack_r <= 1'b0;
    end
  end

  // Software writable registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `CTRL_RESET;
      mode_r <= 32'h00000000;
    end
    else if (wr_done && paddr == `CTRL_OFS)
    begin
      ctrl_r <= pwdata[1:0];
    end
    else if (wr_done && paddr == `MODE_OFS)
    begin
      mode_r <= pwdata;
    end
  end

  // ============================================================
  // Manual inputs
  // ============================================================
  // Commands from software and from the panel switch
  assign apb_set = (wr_done && paddr == `SET_OFS) ? pwdata : 32'h00000000;
  assign apb_clr = (wr_done && paddr == `CLR_OFS) ? pwdata : 32'h00000000;
  assign cmd_set = apb_set | panel_set;
  assign cmd_clr = apb_clr | panel_clr;

  // Thirty-two independent input cells
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : cells
      input_cell u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_r),
        .pulse_mode(mode_r[g]),
        .set_cmd(cmd_set[g]),
        .clr_cmd(cmd_clr[g]),
        .status(status[g])
      );
    end
  endgenerate

  assign manual_binary_input = status;

  // ============================================================
  // Change detection
  // ============================================================
  // Previous values of both signal groups
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_prev_r <= 32'h00000000;
      out_prev_r <= 32'h00000000;
    end
    else
    begin
      in_prev_r <= status;
      out_prev_r <= logic_binary_output;
    end
  end

  assign in_rise = status & ~in_prev_r;
  assign in_fall = ~status & in_prev_r;
  assign out_rise = logic_binary_output & ~out_prev_r;
  assign out_fall = ~logic_binary_output & out_prev_r;

  // Bit k: k[6] input group, k[5] ON, k[4:0] index; disabled directions dropped
  assign cap = {in_rise & {32{ctrl_r[`CTRL_ON_BIT]}}, in_fall & {32{ctrl_r[`CTRL_OFF_BIT]}},
                out_rise & {32{ctrl_r[`CTRL_ON_BIT]}}, out_fall & {32{ctrl_r[`CTRL_OFF_BIT]}}};

  // ============================================================
  // Event batching
  // ============================================================
  // Lowest event of the current batch
  always @*
  begin
    sel_idx = 7'h00;
    sel_any = 1'b0;
    for (i = 127; i >= 0; i = i - 1)
    begin
      if (batch_r[i])
      begin
        sel_idx = i[6:0];
        sel_any = 1'b1;
      end
    end
  end

  // Pending changes move into a batch when the batch is empty
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_r <= {128{1'b0}};
      pend_ts_r <= 32'h00000000;
      batch_r <= {128{1'b0}};
      batch_ts_r <= 32'h00000000;
    end
    else if (!sel_any && (pend_r != 128'h0 || cap != 128'h0))
    begin
      // New batch, stamped at its first change
      batch_r <= pend_r | cap;
      batch_ts_r <= (pend_r != 128'h0) ? pend_ts_r : ms_count_r;
      pend_r <= {128{1'b0}};
    end
    else
    begin
      if (sel_any)
      begin
        batch_r[sel_idx] <= 1'b0;
      end
      if (pend_r == 128'h0 && cap != 128'h0)
      begin
        pend_ts_r <= ms_count_r;
      end
      pend_r <= pend_r | cap;
    end
  end

  // ============================================================
  // Event buffer
  // ============================================================
  assign evt_count = wr_ptr_r - rd_ptr_r;
  assign evt_full = (evt_count == `EVT_DEPTH);
  assign evt_wr = sel_any & ~evt_full;
  assign evt_pop = rd_done & (paddr == `EVT_TIME_OFS) & avail_r;
  assign evt_word = {1'b0, sel_idx, batch_ts_r};

  // Pointers, head valid and overflow flag
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_r <= 5'h00;
      rd_ptr_r <= 5'h00;
      avail_r <= 1'b0;
      ovf_r <= 1'b0;
    end
    else
    begin
      if (evt_wr)
      begin
        wr_ptr_r <= wr_ptr_r + 5'h01;
      end
      if (evt_pop)
      begin
        rd_ptr_r <= rd_ptr_r + 5'h01;
      end
      // Head data settles one cycle after a pointer move
      avail_r <= (evt_count != 5'h00) & ~evt_pop;
      // A lost event wins over a software clear
      if (sel_any && evt_full)
      begin
        ovf_r <= 1'b1;
      end
      else if (wr_done && paddr == `EVT_STAT_OFS && pwdata[`EVT_OVF_BIT])
      begin
        ovf_r <= 1'b0;
      end
    end
  end

  // Event words with time stamps
  event_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(evt_wr),
    .wr_addr(wr_ptr_r[3:0]),
    .wr_data(evt_word),
    .rd_addr(rd_ptr_r[3:0]),
    .rd_data(head)
  );

endmodule // logical_io_signal_bank

// ==== design/logical_io_regs.vh ====
`ifndef LOGICAL_IO_REGS_VH
`define LOGICAL_IO_REGS_VH

// ============================================================
// Timing
// ============================================================
// Clock period in ns
`define CLK_PERIOD_NS 20
// Time stamp tick period in ns (one millisecond)
`define TICK_PERIOD_NS 1000000
// Clock cycles per tick
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
// Pulse mode duration in ms
`define PULSE_MS 5
// Pulse mode duration in ticks
`define PULSE_TICKS (`PULSE_MS * 1000000 / `TICK_PERIOD_NS)

// ============================================================
// Register offsets
// ============================================================
`define CTRL_OFS 8'h00
`define MODE_OFS 8'h04
`define SET_OFS 8'h08
`define CLR_OFS 8'h0c
`define IN_STAT_OFS 8'h10
`define OUT_STAT_OFS 8'h14
`define TIME_OFS 8'h18
`define EVT_STAT_OFS 8'h1c
`define EVT_INFO_OFS 8'h20
`define EVT_TIME_OFS 8'h24

// ============================================================
// Fields and reset values
// ============================================================
// Control: store ON events, store OFF events
`define CTRL_ON_BIT 0
`define CTRL_OFF_BIT 1
`define CTRL_RESET 2'h3
// Event status: overflow flag position
`define EVT_OVF_BIT 8
// Event info: valid flag position
`define EVT_VALID_BIT 31
// Event buffer geometry
`define EVT_ADDR_W 4
`define EVT_DEPTH 5'h10
`define EVT_WIDTH 40

`endif

// ==== design/input_cell.v ====
`include "logical_io_regs.vh"

// ============================================================
// One manual binary input with hold and pulse behaviour
// ============================================================
module input_cell (
  input wire pclk,
  input wire presetn,
  input wire tick,
  input wire pulse_mode,
  input wire set_cmd,
  input wire clr_cmd,
  output wire status
);

  // Pulse length in ticks
  localparam [31:0] PULSE_FULL = `PULSE_TICKS;
  localparam [2:0] PULSE_LOAD = PULSE_FULL[2:0];

  reg status_r; // Current input status
  reg [2:0] cnt_r; // Remaining pulse ticks

  // Status and pulse timer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_r <= 1'b0;
      cnt_r <= 3'h0;
    end
    else if (set_cmd)
    begin
      // Set wins over clear; a repeat set restarts the pulse
      status_r <= 1'b1;
      cnt_r <= PULSE_LOAD;
    end
    else if (clr_cmd)
    begin
      status_r <= 1'b0;
      cnt_r <= 3'h0;
    end
    else if (pulse_mode && status_r && tick)
    begin
      // Timer runs only in pulse mode; hold mode keeps the status
      if (cnt_r <= 3'h1)
      begin
        status_r <= 1'b0;
        cnt_r <= 3'h0;
      end
      else
      begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end

  assign status = status_r;

endmodule // input_cell

// ==== design/event_store.v ====
`include "logical_io_regs.vh"

// ============================================================
// Event buffer memory, registered read
// ============================================================
module event_store (
  input wire pclk,
  input wire presetn,
  input wire wr_en,
  input wire [`EVT_ADDR_W-1:0] wr_addr,
  input wire [`EVT_WIDTH-1:0] wr_data,
  input wire [`EVT_ADDR_W-1:0] rd_addr,
  output wire [`EVT_WIDTH-1:0] rd_data
);

  reg [`EVT_WIDTH-1:0] mem [0:(1<<`EVT_ADDR_W)-1]; // Event words
  reg [`EVT_WIDTH-1:0] rd_data_r; // Read data register

  // Write port
  always @(posedge pclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read port, one cycle latency
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_data_r <= {`EVT_WIDTH{1'b0}};
    end
    else
    begin
      rd_data_r <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_r;

endmodule // event_store

// ==== tb/panel_switch.sv ====
// ============================================================
// Operator panel switch: issues one-cycle set and clear commands
// ============================================================
module panel_switch (
  input wire pclk,
  input wire presetn,
  input wire go,
  input wire [31:0] set_mask,
  input wire [31:0] clr_mask,
  output logic [31:0] panel_set,
  output logic [31:0] panel_clr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Commands only when asked, idle at zero otherwise
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      panel_set <= 32'h0;
      panel_clr <= 32'h0;
    end
    else
    begin
      panel_set <= go ? set_mask : 32'h0;
      panel_clr <= go ? clr_mask : 32'h0;
    end
  end
endmodule // panel_switch

// ==== tb/logical_io_chk.sv ====
// ============================================================
// Port checker
// ============================================================
module logical_io_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [31:0] panel_set,
  input wire [31:0] panel_clr,
  input wire [31:0] manual_binary_input
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] set_q; // Set requests of last cycle
  logic [31:0] clr_q; // Clear requests of last cycle
  logic [31:0] mode_q; // Pulse mode copy
  wire wr_ok = psel && penable && pready && pwrite && !pslverr;
  wire [31:0] set_req = panel_set | ((wr_ok && paddr == 8'h08) ? pwdata : 32'h0);
  wire [31:0] clr_req = panel_clr | ((wr_ok && paddr == 8'h0c) ? pwdata : 32'h0);
  // Track commands and mode writes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      set_q <= 32'h0;
      clr_q <= 32'h0;
      mode_q <= 32'h0;
    end
    else
    begin
      set_q <= set_req;
      clr_q <= clr_req;
      if (wr_ok && paddr == 8'h04)
      begin
        mode_q <= pwdata;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rst_zero; $rose(presetn) |-> manual_binary_input == 32'h0; endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("inputs not zero after reset");
  property p_set_on; (set_q != 32'h0) |-> (manual_binary_input & set_q) == set_q; endproperty
  a_set_on: assert property (p_set_on) else $error("set command not taken");
  property p_clr_off; ((clr_q & ~set_q) != 32'h0) |-> (manual_binary_input & clr_q & ~set_q) == 32'h0; endproperty
  a_clr_off: assert property (p_clr_off) else $error("clear command not taken");
  property p_rise_cause; ((manual_binary_input & ~$past(manual_binary_input)) & ~set_q) == 32'h0; endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("input rose without command");
  property p_hold_keep;
    (($past(manual_binary_input) & ~manual_binary_input) & ~mode_q & ~$past(mode_q) & ~clr_q) == 32'h0;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("held input fell");
  property p_access_two; (psel && !penable) |=> (penable && !pready) ##1 pready; endproperty
  a_access_two: assert property (p_access_two) else $error("access not two cycles");
  property p_err_map; pready |-> (pslverr == !(paddr[1:0] == 2'h0 && paddr <= 8'h24)); endproperty
  a_err_map: assert property (p_err_map) else $error("error response wrong");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready too long");
  c_err: cover property (pready && pslverr);
  c_clr: cover property (clr_q != 32'h0);
  c_pulse_end: cover property ((($past(manual_binary_input) & ~manual_binary_input) & mode_q) != 32'h0);
endmodule // logical_io_chk

bind logical_io_signal_bank logical_io_chk u_logical_io_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .panel_set(panel_set), .panel_clr(panel_clr), .manual_binary_input(manual_binary_input));

// ==== tb/tb_top.sv ====
// ============================================================
// Testbench top
// ============================================================
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic go = 1'b0;
  logic e; // Last error response
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] lbo = 32'h0; // Logic outputs
  logic [31:0] sm = 32'h0;
  logic [31:0] cm = 32'h0;
  logic [31:0] q, m, t0, st;
  logic [4:0] i;
  wire [31:0] prdata, panel_set, panel_clr, mbi;
  wire pready, pslverr;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
  always #10 pclk = ~pclk;
  logical_io_signal_bank #(.TICK_CYCLES(10)) u_logical_io_signal_bank (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .panel_set(panel_set), .panel_clr(panel_clr),
    .logic_binary_output(lbo), .manual_binary_input(mbi));
  panel_switch u_panel_switch (.pclk(pclk), .presetn(presetn), .go(go), .set_mask(sm), .clr_mask(cm),
    .panel_set(panel_set), .panel_clr(panel_clr));
  // Expected event info word
  function automatic [31:0] evt(input g, input on, input [4:0] x);
    return {1'b1, 23'h0, 1'b0, g, on, x};
  endfunction
  // APB transfer, entered just after a rising edge
  task apb(input w, input [7:0] a, input [31:0] d, output [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input [7:0] a, output [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  // Panel command through the partner
  task panel(input [31:0] s, input [31:0] c);
    go <= 1'b1;
    sm <= s;
    cm <= c;
    @(posedge pclk);
    go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // Poll for a stored event, bounded
  task wait_evt(output [31:0] r);
    for (int k = 0; k < 60; k++)
    begin
      rd(8'h20, r);
      if (r[31] === 1'b1) break;
    end
  endtask
  // Empty the buffer and clear overflow
  task drain;
    repeat (150) @(posedge pclk);
    for (int k = 0; k < 40; k++)
    begin
      rd(8'h20, q);
      if (q[31] !== 1'b1) break;
      rd(8'h24, q);
    end
    wr(8'h1c, 32'h100);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done;
    end
  end
  // ============================================================
  // Main sequence
  // ============================================================
  initial
  begin
    void'($urandom(48));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("mbi", 32'h0, mbi)
    rd(8'h00, q); `CHK("ctrl", 32'h3, q)
    rd(8'h04, q); `CHK("mode", 32'h0, q)
    rd(8'h28, q); `CHK("err", 1'b1, e)
    rd(8'h02, q); `CHK("rdz", 32'h0, q)
    // Hold mode, panel set, partial clear, set wins
    m = $urandom;
    panel(m, 32'h0);
    rd(8'h10, q); `CHK("hold", m, q)
    repeat (80) @(posedge pclk);
    `CHK("held", m, mbi)
    wr(8'h0c, m & 32'h0000ffff); `CHK("clr", m & 32'hffff0000, mbi)
    panel(m, m); `CHK("setwin", m, mbi)
    panel(32'h0, 32'hffffffff);
    // Mixed modes, restart of pulse
    m = $urandom;
    wr(8'h04, m);
    wr(8'h08, 32'hffffffff); `CHK("set", 32'hffffffff, mbi)
    repeat (25) @(posedge pclk);
    panel(m, 32'h0);
    repeat (30) @(posedge pclk);
    `CHK("restart", 32'hffffffff, mbi)
    repeat (30) @(posedge pclk);
    `CHK("pulse", ~m, mbi)
    wr(8'h04, 32'h0);
    panel(32'h0, 32'hffffffff);
    // ON only, output group, stamp, OFF dropped
    drain;
    wr(8'h00, 32'h1);
    i = 5'($urandom_range(31));
    rd(8'h18, t0);
    lbo[i] <= 1'b1;
    wait_evt(q); `CHK("on", evt(1'b0, 1'b1, i), q)
    rd(8'h24, st); `CHK("stamp", 1'b1, st >= t0 && st <= t0 + 32'h1)
    lbo <= 32'h0;
    repeat (150) @(posedge pclk);
    rd(8'h20, q); `CHK("offdrop", 1'b0, q[31])
    // Input group events both ways
    wr(8'h00, 32'h3);
    panel(32'h1 << i, 32'h0);
    wait_evt(q); `CHK("in_on", evt(1'b1, 1'b1, i), q)
    rd(8'h24, st);
    panel(32'h0, 32'h1 << i);
    wait_evt(q); `CHK("in_off", evt(1'b1, 1'b0, i), q)
    rd(8'h24, st);
    // Overflow, sticky clear, OFF only
    lbo <= 32'hffffffff;
    repeat (200) @(posedge pclk);
    rd(8'h14, q); `CHK("outstat", 32'hffffffff, q)
    rd(8'h1c, q); `CHK("ovf", 32'h110, q)
    wr(8'h1c, 32'h100);
    rd(8'h1c, q); `CHK("ovfclr", 32'h10, q)
    drain;
    wr(8'h00, 32'h2);
    lbo <= 32'h0;
    wait_evt(q); `CHK("off", evt(1'b0, 1'b0, 5'h0), q)
    // Reset in mid-run
    panel(32'hffffffff, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("rst2", 32'h0, mbi)
    test_done;
  end
endmodule // tb_top
